// *** hw/lcd_pkg.sv ***
// constants and types shared by the panel drive control block
package lcd_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    localparam logic [11:0] PANEL_CTRL_PRIMARY_ADDR     = 12'h0027;
    localparam logic [11:0] PANEL_FRAME_CLOCK_CTRL_ADDR = 12'h0028;
    localparam logic [11:0] DISP_BUF_FIRST_ADDR         = 12'h0F00;
    localparam logic [11:0] DISP_BUF_LAST_ADDR          = 12'h0F7F;
    localparam int          DISP_BUF_BYTES              = 128;
    localparam int          DISP_BUF_IDX_W              = 7;

    localparam int OUTPUT_ENABLE_BIT   = 0;
    localparam int UNDEF_BIT           = 1;
    localparam int PUMP_ENABLE_BIT     = 2;
    localparam int MUX_RATIO_BIT0_POS  = 3;
    localparam int MUX_RATIO_BIT1_POS  = 4;
    localparam int MUX_RATIO_BIT2_POS  = 5;
    localparam int REF_LEVEL_SEL_BIT   = 6;
    localparam int MUX_RATIO_BIT3_POS  = 7;
    localparam int BASE_SEL_W          = 3;

    localparam logic [7:0] PANEL_CTRL_PRIMARY_RST     = 8'h00;
    localparam logic [2:0] PANEL_FRAME_CLOCK_CTRL_RST = 3'h3;

    localparam logic [3:0] MUX_QUARTER   = 4'h8;
    localparam logic [3:0] MUX_EIGHTH    = 4'hA;
    localparam logic [3:0] MUX_SIXTEENTH = 4'hE;

    localparam logic [2:0] BASE_DIV_512 = 3'h0;
    localparam logic [2:0] BASE_DIV_256 = 3'h1;
    localparam logic [2:0] BASE_DIV_128 = 3'h2;
    localparam logic [2:0] BASE_DIV_64  = 3'h3;
    localparam int         BASE_SUB_BIT = 2;

    localparam int EXP_DIV_512 = 9;
    localparam int EXP_DIV_256 = 8;
    localparam int EXP_DIV_128 = 7;
    localparam int EXP_DIV_64  = 6;

    localparam logic [4:0] ROWS_QUARTER    = 5'h04;
    localparam logic [4:0] ROWS_EIGHTH     = 5'h08;
    localparam logic [4:0] ROWS_SIXTEENTH  = 5'h10;
    localparam logic [6:0] SLICE_QUARTER   = 7'h54;
    localparam logic [6:0] SLICE_EIGHTH    = 7'h2A;
    localparam logic [6:0] SLICE_SIXTEENTH = 7'h15;

    localparam int SEG_DEDICATED = 40;
    localparam int SEG_SHARED    = 20;
    localparam int COM_DEDICATED = 5;
    localparam int COM_SHARED    = 11;
    localparam int SEG_COUNT     = SEG_DEDICATED + SEG_SHARED;
    localparam int COM_COUNT     = COM_DEDICATED + COM_SHARED;
    localparam int ROW_W         = 4;
    localparam int SEG_PER_BYTE  = 8;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_STOP = 2'b01
    } stop_state_t;
endpackage

// *** hw/timing_if.sv ***
// interface between control logic and frame timer
`timescale 1ns/10ps
interface timing_if;
    logic [2:0] base_sel;
    logic [4:0] rows;
    logic [6:0] slice_len;
    logic       run;
    logic [3:0] row;
    logic       frame_tick;

    modport timer (input base_sel, input rows, input slice_len, input run, output row, output frame_tick);
    modport ctrl  (output base_sel, output rows, output slice_len, output run, input row, input frame_tick);
endinterface

// *** hw/frame_timer.sv ***
// base clock selection, slice and row counters of the panel scan
`timescale 1ns/10ps
module frame_timer
    import lcd_pkg::*;
#(
    parameter int PRESCALE_W = EXP_DIV_512
) (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic ce_in,
    input  wire logic sub_tick_in,
    timing_if.timer   tim
);
    logic [PRESCALE_W-1:0] pre_q;
    logic [6:0]            slice_q;
    logic [3:0]            row_q;
    logic                  frame_q;
    logic                  base_tick;
    logic                  last_slice;
    logic                  last_row;

    // free-running divider with no halt input, so debug breaks leave it alone
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pre_q <= '0;
        end else if (ce_in) begin
            pre_q <= pre_q + 1'b1; // [R14]
        end
    end

    always_comb begin
        case (tim.base_sel)
            BASE_DIV_512: base_tick = &pre_q[EXP_DIV_512-1:0]; // [R10]
            BASE_DIV_256: base_tick = &pre_q[EXP_DIV_256-1:0]; // [R10]
            BASE_DIV_128: base_tick = &pre_q[EXP_DIV_128-1:0]; // [R10]
            BASE_DIV_64:  base_tick = &pre_q[EXP_DIV_64-1:0]; // [R10]
            default:      base_tick = sub_tick_in; // [R10]
        endcase
    end

    assign last_slice = (slice_q >= (tim.slice_len - 7'h01));
    assign last_row   = (row_q >= ROW_W'(tim.rows - 5'h01));

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            slice_q <= '0;
            row_q   <= '0;
            frame_q <= 1'b0;
        end else if (ce_in) begin
            frame_q <= 1'b0;
            if (!tim.run) begin
                slice_q <= '0;
                row_q   <= '0;
            end else if (base_tick) begin
                if (last_slice) begin
                    slice_q <= '0; // [R12]
                    if (last_row) begin
                        row_q   <= '0; // [R17]
                        frame_q <= 1'b1; // [R12]
                    end else begin
                        row_q <= row_q + 4'h1; // [R17]
                    end
                end else begin
                    slice_q <= slice_q + 7'h01; // [R12]
                end
            end
        end
    end

    assign tim.row        = row_q;
    assign tim.frame_tick = frame_q;
endmodule

// *** hw/lcd_panel_drive_control.sv ***
// register file, display buffer, blanking and pin drive of the panel driver
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps

// Summary of operation
// R1: drive 40 dedicated and 20 shared segments, 5 dedicated and 11 shared commons.
// R2: 60 segment columns over 4, 8 or 16 common rows.
// R3: mux codes 1000, 1010, 1110 give 1/4, 1/8, 1/16; others reserved.
// R4: software never writes reserved mux or base clock codes.
// R5: primary control resets to zero, bit 1 undefined, mux starts reserved.
// R6: output enable bit set drives panel waveforms.
// R7: output enable clear holds every segment and common at ground; shared pins float instead while the mux code is reserved.
// R8: software sets the charge pump bit whenever the panel is used.
// R9: software sets reference select to suit supply voltage.
// R10: base clock is main clock over 512, 256, 128, 64, or sub clock.
// R11: frame clock control resets with base select 011.
// R12: frame is base clock over 84x4, 42x8 or 21x16.
// R13: software picks base clock to suit the main clock frequency.
// R14: frame divider runs on regardless of processor halts.
// R15: pixels fetched continuously from 128 byte buffer, 1 lights pixel.
// R16: stop mode clears output enable; leaving stop sets it again.
// R17: rows scanned upward from 0, one equal slice each.
// R18: both control registers are byte wide read and write.
module lcd_panel_drive_control
    import lcd_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              ce_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    input  wire logic              sub_tick_in,
    input  wire logic              stop_mode_in,
    output logic      [DATA_W-1:0] rdata_out,
    output logic [SEG_COUNT-1:0]   seg_out,
    output logic [COM_COUNT-1:0]   com_out,
    output logic                   shared_pin_drive_en_out,
    output logic                   frame_pol_out,
    output logic                   charge_pump_enable_out,
    output logic                   reference_level_select_out
);
    timing_if tim ();

    logic [DATA_W-1:0]    disp_buf [DISP_BUF_BYTES];
    logic [DATA_W-1:0]    rdata_q;
    logic [SEG_COUNT-1:0] seg_q;
    logic [SEG_COUNT-1:0] seg_d;
    logic [COM_COUNT-1:0] com_q;
    logic [COM_COUNT-1:0] com_d;
    logic [SEG_COUNT-1:0] pix_row;
    logic                 shared_en_q;
    logic                 frame_pol_q;

    logic [3:0]           mux_ratio_q;
    logic                 reference_level_select_q;
    logic                 charge_pump_enable_q;
    logic                 panel_output_enable_q;
    logic [2:0]           frame_base_clock_select_q;
    logic                 restore_q;
    stop_state_t          stop_st_q;

    logic                 wr_primary;
    logic                 wr_frame_clk;
    logic                 buf_hit;
    logic [DATA_W-1:0]    primary_view;
    logic [DATA_W-1:0]    frame_clk_view;
    logic                 duty_valid;
    logic [4:0]           rows_d;
    logic [6:0]           slice_d;
    logic                 drive_active;

    assign wr_primary   = wr_in && (addr_in == PANEL_CTRL_PRIMARY_ADDR);
    assign wr_frame_clk = wr_in && (addr_in == PANEL_FRAME_CLOCK_CTRL_ADDR);
    assign buf_hit      = (addr_in >= DISP_BUF_FIRST_ADDR) && (addr_in <= DISP_BUF_LAST_ADDR);

    // read view of both control registers, undefined bits read as zero
    always_comb begin
        primary_view                     = 8'h00;
        primary_view[MUX_RATIO_BIT3_POS] = mux_ratio_q[3];
        primary_view[REF_LEVEL_SEL_BIT]  = reference_level_select_q;
        primary_view[MUX_RATIO_BIT2_POS] = mux_ratio_q[2];
        primary_view[MUX_RATIO_BIT1_POS] = mux_ratio_q[1];
        primary_view[MUX_RATIO_BIT0_POS] = mux_ratio_q[0];
        primary_view[PUMP_ENABLE_BIT]    = charge_pump_enable_q;
        primary_view[OUTPUT_ENABLE_BIT]  = panel_output_enable_q;
        frame_clk_view                   = {5'h00, frame_base_clock_select_q};
    end

    // mux ratio decode into rows and slice length
    always_comb begin
        case (mux_ratio_q)
            MUX_QUARTER: begin
                duty_valid = 1'b1; // [R3]
                rows_d     = ROWS_QUARTER; // [R2]
                slice_d    = SLICE_QUARTER; // [R12]
            end
            MUX_EIGHTH: begin
                duty_valid = 1'b1; // [R3]
                rows_d     = ROWS_EIGHTH; // [R2]
                slice_d    = SLICE_EIGHTH; // [R12]
            end
            MUX_SIXTEENTH: begin
                duty_valid = 1'b1; // [R3]
                rows_d     = ROWS_SIXTEENTH; // [R2]
                slice_d    = SLICE_SIXTEENTH; // [R12]
            end
            default: begin
                // reserved codes stop the scan and keep the panel blank
                duty_valid = 1'b0; // [R3]
                rows_d     = ROWS_QUARTER;
                slice_d    = SLICE_QUARTER;
            end
        endcase
    end

    assign tim.base_sel  = frame_base_clock_select_q;
    assign tim.rows      = rows_d;
    assign tim.slice_len = slice_d;
    assign tim.run       = duty_valid;

    frame_timer #(
        .PRESCALE_W (EXP_DIV_512)
    ) u_frame_timer (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .ce_in       (ce_in),
        .sub_tick_in (sub_tick_in),
        .tim         (tim)
    );

    // primary control fields other than output enable
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            mux_ratio_q              <= PANEL_CTRL_PRIMARY_RST[MUX_RATIO_BIT0_POS +: 4]; // [R5]
            reference_level_select_q <= PANEL_CTRL_PRIMARY_RST[REF_LEVEL_SEL_BIT]; // [R5]
            charge_pump_enable_q     <= PANEL_CTRL_PRIMARY_RST[PUMP_ENABLE_BIT]; // [R5]
        end else if (ce_in && wr_primary) begin
            mux_ratio_q              <= {wdata_in[MUX_RATIO_BIT3_POS], wdata_in[MUX_RATIO_BIT2_POS],
                                         wdata_in[MUX_RATIO_BIT1_POS], wdata_in[MUX_RATIO_BIT0_POS]}; // [R18]
            reference_level_select_q <= wdata_in[REF_LEVEL_SEL_BIT]; // [R18]
            charge_pump_enable_q     <= wdata_in[PUMP_ENABLE_BIT]; // [R18]
        end
    end

    // frame clock select register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            frame_base_clock_select_q <= PANEL_FRAME_CLOCK_CTRL_RST; // [R11]
        end else if (ce_in && wr_frame_clk) begin
            frame_base_clock_select_q <= wdata_in[BASE_SEL_W-1:0]; // [R18]
        end
    end

    // output enable with automatic blanking across stop mode
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            panel_output_enable_q <= PANEL_CTRL_PRIMARY_RST[OUTPUT_ENABLE_BIT]; // [R5]
            restore_q             <= 1'b0;
            stop_st_q             <= ST_RUN;
        end else if (ce_in) begin
            case (stop_st_q)
                ST_RUN: begin
                    if (stop_mode_in) begin
                        // hardware clear wins over a write in the same cycle
                        stop_st_q             <= ST_STOP;
                        restore_q             <= panel_output_enable_q; // [R16]
                        panel_output_enable_q <= 1'b0; // [R16]
                    end else if (wr_primary) begin
                        panel_output_enable_q <= wdata_in[OUTPUT_ENABLE_BIT]; // [R18]
                    end
                end
                ST_STOP: begin
                    if (!stop_mode_in) begin
                        stop_st_q <= ST_RUN;
                        restore_q <= 1'b0;
                        if (restore_q) begin
                            panel_output_enable_q <= 1'b1; // [R16]
                        end
                    end
                end
                default: begin
                    stop_st_q             <= ST_RUN;
                    panel_output_enable_q <= 1'b0;
                    restore_q             <= 1'b0;
                end
            endcase
        end
    end

    // display buffer, written by software
    always_ff @(posedge clk_in) begin
        if (ce_in && wr_in && buf_hit) begin
            disp_buf[addr_in[DISP_BUF_IDX_W-1:0]] <= wdata_in;
        end
    end

    // byte for segment group g, row r sits at g*16 + r
    for (genvar s = 0; s < SEG_COUNT; s++) begin : g_seg
        localparam int GRP = s / SEG_PER_BYTE;
        localparam int BIT = s % SEG_PER_BYTE;
        assign pix_row[s] = disp_buf[{3'(GRP), tim.row}][BIT]; // [R15]
    end

    assign drive_active = panel_output_enable_q && duty_valid;

    always_comb begin
        if (drive_active) begin
            seg_d = pix_row; // [R6] [R15]
            com_d = COM_COUNT'(1) << tim.row; // [R17]
        end else begin
            seg_d = '0; // [R7]
            com_d = '0; // [R7]
        end
    end

    // pin drive, segment and common levels
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            seg_q <= '0; // [R1]
            com_q <= '0; // [R1]
        end else if (ce_in) begin
            seg_q <= seg_d; // [R1] [R6] [R7]
            com_q <= com_d; // [R1] [R6] [R7]
        end
    end

    // shared pins float after reset until a valid mux ratio is set
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            shared_en_q <= 1'b0;
        end else if (ce_in) begin
            shared_en_q <= duty_valid; // [R1]
        end
    end

    // drive polarity flips every frame for ac drive
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            frame_pol_q <= 1'b0;
        end else if (ce_in) begin
            if (!drive_active) begin
                frame_pol_q <= 1'b0; // [R7]
            end else if (tim.frame_tick) begin
                frame_pol_q <= ~frame_pol_q; // [R12]
            end
        end
    end

    // read data, one cycle after the strobe only
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rdata_q <= 8'h00;
        end else if (ce_in) begin
            if (rd_in) begin
                if (addr_in == PANEL_CTRL_PRIMARY_ADDR) begin
                    rdata_q <= primary_view; // [R18]
                end else if (addr_in == PANEL_FRAME_CLOCK_CTRL_ADDR) begin
                    rdata_q <= frame_clk_view; // [R18]
                end else if (buf_hit) begin
                    rdata_q <= disp_buf[addr_in[DISP_BUF_IDX_W-1:0]];
                end else begin
                    rdata_q <= 8'h00;
                end
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign rdata_out                  = rdata_q;
    assign seg_out                    = seg_q;
    assign com_out                    = com_q;
    assign shared_pin_drive_en_out    = shared_en_q;
    assign frame_pol_out              = frame_pol_q;
    assign charge_pump_enable_out     = charge_pump_enable_q;
    assign reference_level_select_out = reference_level_select_q;
endmodule

// *** sim/lcd_panel_drive_control_checker.sv ***
// port level assertions for the panel drive control block
`timescale 1ns/10ps
module lcd_panel_drive_control_checker
    import lcd_pkg::*;
(
    input wire logic              clk_in,
    input wire logic              rst_b_in,
    input wire logic              ce_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic              stop_mode_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic [SEG_COUNT-1:0] seg_out,
    input wire logic [COM_COUNT-1:0] com_out,
    input wire logic              shared_pin_drive_en_out,
    input wire logic              frame_pol_out,
    input wire logic              charge_pump_enable_out,
    input wire logic              reference_level_select_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    logic [DATA_W-1:0] wdata_q;
    logic              prim_rd;
    logic              sel_rd;
    logic              void_rd;
    logic              prim_wr;

    // write data one cycle back, for the write-to-output check
    always_ff @(posedge clk_in) begin
        wdata_q <= wdata_in;
    end

    assign prim_rd = rd_in && ce_in && addr_in == PANEL_CTRL_PRIMARY_ADDR;
    assign sel_rd  = rd_in && ce_in && addr_in == PANEL_FRAME_CLOCK_CTRL_ADDR;
    assign prim_wr = wr_in && ce_in && addr_in == PANEL_CTRL_PRIMARY_ADDR;
    assign void_rd = rd_in && ce_in && addr_in != PANEL_CTRL_PRIMARY_ADDR
                     && addr_in != PANEL_FRAME_CLOCK_CTRL_ADDR && addr_in[11:7] != 5'h1E;

    a_rdata_idle: assert property ($past(ce_in) && !$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not zero outside read cycle");
    a_prim_readback: assert property (prim_rd |=> rdata_out[1] == 1'b0
        && rdata_out[2] == charge_pump_enable_out && rdata_out[6] == reference_level_select_out)
        else $error("primary control read back mismatch");
    a_sel_upper_zero: assert property (sel_rd |=> rdata_out[7:3] == 5'h00)
        else $error("frame clock control upper bits not zero");
    a_void_read: assert property (void_rd |=> rdata_out == 8'h00)
        else $error("unmapped read returned data");
    a_pump_write: assert property (prim_wr |=> charge_pump_enable_out == wdata_q[2]
        && reference_level_select_out == wdata_q[6])
        else $error("pump or reference output not following write");
    a_com_onehot: assert property ($onehot0(com_out))
        else $error("more than one common row active");
    a_blank_segs: assert property (com_out == 16'h0000 |-> seg_out == 60'h0)
        else $error("segments driven while panel blanked");
    a_row_order: assert property ($changed(com_out) && $past(com_out) != 16'h0000 && com_out != 16'h0000
        |-> com_out == 16'h0001 || com_out == ($past(com_out) << 1))
        else $error("common rows not scanned upward");
    a_shared_drive: assert property (com_out != 16'h0000 |-> shared_pin_drive_en_out)
        else $error("shared pins not driven while scanning");
    a_stop_blank: assert property ($rose(stop_mode_in) |-> ##2 (com_out == 16'h0000 && seg_out == 60'h0))
        else $error("panel not blanked on stop entry");
    a_pol_flip: assert property ($changed(frame_pol_out) |-> com_out == 16'h0001 || com_out == 16'h0000)
        else $error("polarity changed away from a frame start");

    c_last_row: cover property (com_out == 16'h8000);
    c_stop: cover property ($rose(stop_mode_in) && com_out != 16'h0000);
    c_void_rd: cover property (void_rd);
endmodule

bind lcd_panel_drive_control lcd_panel_drive_control_checker u_chk (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .stop_mode_in(stop_mode_in), .rdata_out(rdata_out),
    .seg_out(seg_out), .com_out(com_out), .shared_pin_drive_en_out(shared_pin_drive_en_out),
    .frame_pol_out(frame_pol_out), .charge_pump_enable_out(charge_pump_enable_out),
    .reference_level_select_out(reference_level_select_out)
);

// *** sim/lcd_panel_model.sv ***
// passive panel glass: records which common rows were energised
`timescale 1ns/10ps
module lcd_panel_model
    import lcd_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 clear_in,
    input  wire logic [SEG_COUNT-1:0] seg_in,
    input  wire logic [COM_COUNT-1:0] com_in,
    output logic      [COM_COUNT-1:0] rows_seen_out,
    output logic      [SEG_COUNT-1:0] row0_pix_out
);
    // glass rows and columns only light where energised
    always_ff @(posedge clk_in) begin
        if (clear_in) begin
            rows_seen_out <= '0;
        end else begin
            rows_seen_out <= rows_seen_out | com_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (com_in == 16'h0001) begin
            row0_pix_out <= seg_in;
        end
    end
endmodule

// *** sim/tb_lcd_panel_drive_control.sv ***
// self-checking testbench of the panel drive control block
`timescale 1ns/10ps
module tb_lcd_panel_drive_control;
    import lcd_pkg::*;

    logic              clk_in = 1'b0;
    logic              rst_b_in = 1'b0;
    logic [ADDR_W-1:0] addr_in = 12'h000;
    logic [DATA_W-1:0] wdata_in = 8'h00;
    logic              wr_in = 1'b0;
    logic              rd_in = 1'b0;
    logic              sub_tick_in = 1'b0;
    logic              stop_mode_in = 1'b0;
    logic              ce_in = 1'b1;
    logic              clear = 1'b1;
    logic [1:0]        sub_cnt = 2'h0;
    logic [DATA_W-1:0] rdata_out;
    logic [SEG_COUNT-1:0] seg_out;
    logic [COM_COUNT-1:0] com_out;
    logic              shared_pin_drive_en_out;
    logic              charge_pump_enable_out;
    logic              reference_level_select_out;
    logic              frame_pol_out;
    logic [COM_COUNT-1:0] rows_seen;
    logic [SEG_COUNT-1:0] row0_pix;
    logic [SEG_COUNT-1:0] row0_exp;
    logic [7:0]        rd_val;
    int                error_cnt = 0;
    int                checked = 0;

    lcd_panel_drive_control uut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .sub_tick_in(sub_tick_in), .stop_mode_in(stop_mode_in),
        .rdata_out(rdata_out), .seg_out(seg_out), .com_out(com_out),
        .shared_pin_drive_en_out(shared_pin_drive_en_out), .frame_pol_out(frame_pol_out),
        .charge_pump_enable_out(charge_pump_enable_out),
        .reference_level_select_out(reference_level_select_out)
    );

    lcd_panel_model panel (
        .clk_in(clk_in), .clear_in(clear), .seg_in(seg_out), .com_in(com_out),
        .rows_seen_out(rows_seen), .row0_pix_out(row0_pix)
    );

    always #5 clk_in = ~clk_in;

    // sub clock tick, one pulse every 4 cycles
    always @(posedge clk_in) begin
        sub_cnt <= sub_cnt + 2'h1;
        sub_tick_in <= (sub_cnt == 2'h3);
    end

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rd_val = rdata_out;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // reserved code first so the scan restarts at row 0
    task automatic start(input logic [7:0] sel, input logic [7:0] prim);
        wr(12'h028, sel);
        wr(12'h027, 8'h8D);
        wr(12'h027, prim);
        wait_cyc(2);
    endtask

    // cycles between two row changes, and the step between them
    task automatic meas(input int exp);
        logic [15:0] c0;
        int          n;
        for (int k = 0; k < 2; k++) begin
            c0 = com_out;
            n = 0;
            while (com_out === c0 && n < 25000) begin
                @(posedge clk_in);
                #1 n++;
            end
        end
        chk("row_len", n, exp);
        chk("row_step", com_out, {c0[14:0], 1'b0});
    endtask

    task automatic t_reset();
        rd(12'h027);
        chk("prim_rst", rd_val, 8'h00);
        rd(12'h028);
        chk("sel_rst", rd_val, 8'h03);
        chk("com_rst", com_out, 16'h0000);
    endtask

    task automatic t_regs();
        wr(12'h027, 8'h56);
        rd(12'h027);
        chk("prim_rw", rd_val, 8'h54);
        chk("pump_out", charge_pump_enable_out, 1'b1);
        chk("ref_out", reference_level_select_out, 1'b1);
        wr(12'h028, 8'hFF);
        rd(12'h028);
        chk("sel_rw", rd_val, 8'h07);
        wr(12'h123, 8'hFF);
        rd(12'h123);
        chk("void_rd", rd_val, 8'h00);
        for (int g = 0; g < 8; g++) begin
            wr(12'hF00 + 12'(g * 16), 8'hA0 + 8'(g));
        end
        for (int s = 0; s < SEG_COUNT; s++) begin
            row0_exp[s] = ((8'hA0 + 8'(s / 8)) >> (s % 8)) & 8'h01;
        end
        rd(12'hF30);
        chk("buf_rd", rd_val, 8'hA3);
    endtask

    task automatic t_duty();
        logic [7:0] prim [3];
        int         slice [3];
        prim = '{8'h85, 8'h95, 8'hB5};
        slice = '{84, 42, 21};
        for (int i = 0; i < 3; i++) begin
            start(8'h03, prim[i]);
            chk("com_first", com_out, 16'h0001);
            chk("seg_row0", seg_out, row0_exp);
            chk("shared_en", shared_pin_drive_en_out, 1'b1);
            meas(slice[i] * 64);
        end
        chk("panel_row0", row0_pix, row0_exp);
    endtask

    task automatic t_reserved();
        logic [7:0] code [2];
        code = '{8'h8D, 8'h05};
        for (int i = 0; i < 2; i++) begin
            wr(12'h027, code[i]);
            wait_cyc(3);
            chk("rsv_com", com_out, 16'h0000);
            chk("rsv_shared", shared_pin_drive_en_out, 1'b0);
        end
    endtask

    task automatic t_blank();
        start(8'h03, 8'hB5);
        wr(12'h027, 8'hB4);
        wait_cyc(2);
        chk("blank_com", com_out, 16'h0000);
        chk("blank_seg", seg_out, 60'h0);
        chk("blank_pol", frame_pol_out, 1'b0);
        wr(12'h027, 8'hB5);
        wait_cyc(2);
        chk("unblank", com_out != 16'h0000, 1'b1);
        ce_in <= 1'b0;
        wr(12'h027, 8'hB4);
        wait_cyc(2);
        chk("ce_hold", com_out != 16'h0000, 1'b1);
        ce_in <= 1'b1;
    endtask

    task automatic t_base();
        for (int k = 0; k < 4; k++) begin
            start(8'(k), 8'hB5);
            meas(21 * (512 >> k));
        end
        start(8'h04, 8'hB5);
        meas(21 * 4);
        @(posedge clk_in);
        clear <= 1'b1;
        @(posedge clk_in);
        clear <= 1'b0;
        wait_cyc(16 * 21 * 4 + 8);
        chk("rows_seen", rows_seen, 16'hFFFF);
    endtask

    task automatic t_stop();
        start(8'h03, 8'hB5);
        @(posedge clk_in);
        stop_mode_in <= 1'b1;
        wait_cyc(3);
        chk("stop_com", com_out, 16'h0000);
        rd(12'h027);
        chk("stop_prim", rd_val, 8'hB4);
        @(posedge clk_in);
        stop_mode_in <= 1'b0;
        wait_cyc(3);
        rd(12'h027);
        chk("wake_prim", rd_val, 8'hB5);
        chk("wake_com", com_out != 16'h0000, 1'b1);
    endtask

    task automatic end_sim();
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_regs();
        t_duty();
        t_reserved();
        t_blank();
        t_stop();
        t_base();
        end_sim();
    end

    initial begin
        repeat (90000) @(posedge clk_in);
        error_cnt++;
        end_sim();
    end
endmodule
